// ### rea_map.svh
// Purpose: Register offsets, field positions, reset values and timing figures of the
//          reactive energy accumulator.
// Assumes: Eight-bit register addresses on a plain strobe port.
// Notes:   Included by the design module, the assertion module and the testbench.
//
// Contract
// R1: Add signed 16-bit offset to reactive power
// R2: Offset of 256 counts equals one LSB
// R3: Reactive power is signed by phase angle
// R4: Polarity clear: flag on positive-to-negative change
// R5: Polarity set: flag on negative-to-positive change
// R6: Enabled sign flag holds interrupt until cleared
// R7: Below threshold: skip accumulation, set no-load flag
// R8: Enabled no-load flag holds interrupt until cleared
// R9: Two-bit threshold field: off, 0.015%, 0.0075%, 0.0037%
// R10: 49-bit signed accumulator, upper 24 bits readable
// R11: One sample accumulated every five clocks
// R12: Both mode bits clear: signed accumulation
// R13: Both mode bits set: absolute mode wins
// R14: Antitamper: sign follows active power sign
// R15: Absolute mode accumulates reactive power magnitude
// R16: Divide by 8-bit divider, zero means one
// R17: Read-clear read returns energy, clears upper bits
// R18: Waveform samples at 25.6 to 3.2 kSPS
// R19: Energy wraps through full scale and continues
// R20: Flags for half-full and for wrap events
// R21: Gain scales power by one plus gain/4096
// R22: Half-full on bit 22 leaving sign; wrap on flip
// R23: Flags sticky until cleared, ORed into one request
`ifndef REA_MAP_SVH
`define REA_MAP_SVH

// Register offsets
`define REA_ADDR_WAVE_SEL 8'h0D
`define REA_ADDR_NL_CFG 8'h0E
`define REA_ADDR_ACC_CFG 8'h0F
`define REA_ADDR_EN_LOW 8'hD9
`define REA_ADDR_EN_HIGH 8'hDB
`define REA_ADDR_STATUS 8'hDC
`define REA_ADDR_OFFSET 8'h40
`define REA_ADDR_GAIN 8'h41
`define REA_ADDR_DIVIDER 8'h42
`define REA_ADDR_ENERGY 8'h43
`define REA_ADDR_ENERGY_RC 8'h44
`define REA_ADDR_WAVE_DATA 8'h45

// Field positions
`define REA_ACC_ANTITAMPER_BIT 2
`define REA_ACC_ABSOLUTE_BIT 3
`define REA_ACC_POLARITY_BIT 7
`define REA_NL_FIELD_HI 3
`define REA_NL_FIELD_LO 2
`define REA_ST_SIGN_BIT 0
`define REA_ST_NOLOAD_BIT 1
`define REA_ST_HALF_BIT 2
`define REA_ST_WRAP_BIT 3
`define REA_ENH_WAVEFORM_SAMPLING_ENABLE_BIT 0
`define REA_WAVE_SRC_HI 2
`define REA_WAVE_SRC_LO 0
`define REA_WAVE_RATE_HI 4
`define REA_WAVE_RATE_LO 3
`define REA_WAVE_SRC_REACTIVE 3'h3

// Reset values
`define REA_RST_BYTE 8'h00
`define REA_RST_OFFSET 16'h0000
`define REA_RST_GAIN 12'h000

// Arithmetic layout
`define REA_GAIN_SHIFT 12
`define REA_OFFSET_FRAC 8
`define REA_ENERGY_HI 48
`define REA_ENERGY_LO 25
`define REA_HALF_BIT 22

// Timing: accumulation period in master clocks, fastest waveform rate
`define REA_ACC_PERIOD 5
`define REA_CLK_HZ 125000000
`define REA_WAVE_FAST_HZ 25600

// No-load thresholds in parts per million of multiplier full scale
`define REA_NL_PPM_1 150
`define REA_NL_PPM_2 75
`define REA_NL_PPM_3 37
`define REA_PPM_FULL 1000000

`endif

// ### rea_pkg.sv
// Purpose: Types shared by the reactive energy accumulator.
// Assumes: Constants come from rea_map.svh.
// Notes:   The whole module state travels as one packed struct.
package rea_pkg;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;   // Register address
    logic [31:0] wdata; // Write data
    logic wr;           // Write strobe
    logic rd;           // Read strobe
  } rea_bus_t;

  // Complete state of the block
  typedef struct packed {
    logic [7:0] wave_sel;      // Waveform source and rate
    logic [7:0] nl_cfg;        // No-load threshold selection
    logic [7:0] acc_cfg;       // Accumulation mode and sign polarity
    logic [7:0] en_low;        // Interrupt enables
    logic [7:0] en_high;       // Waveform sampling enable
    logic [7:0] status;        // Sticky event flags
    logic [15:0] offset;       // Signed reactive offset
    logic [11:0] gain;         // Signed reactive gain
    logic [7:0] divider;       // Energy divider
    logic [48:0] acc;          // Internal energy accumulator
    logic [2:0] phase;         // Position in the five-clock period
    logic prev_neg;            // Sign of previous sample
    logic prev_valid;          // A previous sample exists
    logic [15:0] wave_cnt;     // Waveform rate counter
    logic [23:0] wave_data;    // Last waveform sample
    logic wave_valid;          // Waveform sample strobe
    logic [31:0] rdata;        // Read data
    logic irq;                 // Interrupt request
  } rea_state_t;

endpackage

// ### rea_accum.sv
// Purpose: Reactive power gain, offset, sign and no-load handling, division and
//          49-bit energy accumulation with flags and a combined interrupt request.
// Assumes: Reactive and active power samples are synchronous to clk and held
//          stable by the upstream filter.
// Notes:   One accumulation every five clocks; read data arrives one cycle late.
`timescale 1ns/1ps
`include "rea_map.svh"

module rea_accum
  import rea_pkg::*;
#(
  parameter int WAVE_CYCLES = (`REA_CLK_HZ + `REA_WAVE_FAST_HZ - 1) / `REA_WAVE_FAST_HZ
) (
  input wire logic clk,
  input wire logic reset,
  input wire rea_bus_t bus,
  output logic [31:0] rdata,
  input wire logic signed [23:0] reactive_power,
  input wire logic active_power_neg,
  output logic irq,
  output logic [23:0] wave_data,
  output logic wave_valid
);

  // Slowest rate is eight times the fastest period, counted in 16 bits
  if (WAVE_CYCLES < 1 || WAVE_CYCLES * 8 > 65535) begin : g_bad_wave_cycles
    $error("WAVE_CYCLES out of range");
  end

  localparam logic [2:0] PHASE_LAST = 3'(`REA_ACC_PERIOD - 1);
  // Full scale of the fractional work value
  localparam longint FULL_SCALE = 64'sh0000_0000_8000_0000;
  localparam logic [39:0] TH1 = 40'(FULL_SCALE * `REA_NL_PPM_1 / `REA_PPM_FULL);
  localparam logic [39:0] TH2 = 40'(FULL_SCALE * `REA_NL_PPM_2 / `REA_PPM_FULL);
  localparam logic [39:0] TH3 = 40'(FULL_SCALE * `REA_NL_PPM_3 / `REA_PPM_FULL);

  rea_state_t s_reg;  // Registered state
  rea_state_t s_next; // Next state

  // Datapath signals
  logic signed [39:0] q_ext;     // Input power, widened
  logic signed [39:0] gain_prod; // Power times gain word
  logic signed [39:0] gained;    // Gain-corrected power
  logic signed [39:0] work;      // Power with eight fractional bits plus offset
  logic work_neg;                // Sign of reactive power
  logic [39:0] mag;              // Magnitude of reactive power
  logic [39:0] div_eff;          // Effective divider
  logic [39:0] quot;             // Divided magnitude
  logic [39:0] thresh;           // Selected no-load threshold
  logic no_load;                 // Power below threshold
  logic negate;                  // Subtract this sample
  logic [48:0] delta;            // Signed step for the accumulator
  logic [48:0] acc_sum;          // Accumulator after the step
  logic [1:0] nl_sel;            // Threshold field
  logic use_abs;                 // Absolute mode active
  logic use_tamper;              // Antitamper mode active

  // Gain correction: power times one plus gain over 4096
  assign q_ext = 40'(reactive_power);
  assign gain_prod = q_ext * 40'($signed(s_reg.gain)); // R21
  assign gained = q_ext + (gain_prod >>> `REA_GAIN_SHIFT); // R21

  // Offset carries eight fractional bits, so 256 counts equal one LSB
  assign work = (gained <<< `REA_OFFSET_FRAC) + 40'($signed(s_reg.offset)); // R1 R2

  // Signed result, sign taken from the corrected value
  assign work_neg = work[39]; // R3
  assign mag = work_neg ? 40'(-work) : 40'(work);

  // Zero divider behaves as one
  assign div_eff = (s_reg.divider == 8'h00) ? 40'h00_0000_0001 : {32'h0000_0000, s_reg.divider}; // R16
  assign quot = mag / div_eff; // R16

  // Threshold selection; zero field disables detection
  assign nl_sel = s_reg.nl_cfg[`REA_NL_FIELD_HI:`REA_NL_FIELD_LO];
  always_comb begin
    case (nl_sel) // R9
      2'h1: thresh = TH1;
      2'h2: thresh = TH2;
      2'h3: thresh = TH3;
      default: thresh = 40'h00_0000_0000;
    endcase
  end
  assign no_load = (nl_sel != 2'h0) && (mag < thresh); // R7 R9

  // Mode decode: absolute wins when both bits are set
  assign use_abs = s_reg.acc_cfg[`REA_ACC_ABSOLUTE_BIT]; // R13 R15
  assign use_tamper = s_reg.acc_cfg[`REA_ACC_ANTITAMPER_BIT] && !use_abs; // R13
  always_comb begin
    if (use_abs) begin
      negate = 1'b0; // R15
    end else if (use_tamper) begin
      negate = work_neg ^ active_power_neg; // R14
    end else begin
      negate = work_neg; // R12
    end
  end
  assign delta = negate ? 49'(-{9'h000, quot}) : {9'h000, quot};
  assign acc_sum = s_reg.acc + delta; // R10 R19

  // Next-state logic for registers, accumulator, flags and waveform
  always_comb begin
    logic step;         // Accumulation cycle
    logic [48:0] acc_n; // Accumulator after this cycle
    logic [23:0] e_old; // Readable energy before
    logic [23:0] e_new; // Readable energy after
    logic [7:0] ev;     // Events this cycle
    logic [1:0] rate;   // Waveform rate select
    logic [15:0] wlim;  // Waveform period
    step = 1'b0;
    acc_n = '0;
    e_old = '0;
    e_new = '0;
    ev = '0;
    rate = '0;
    wlim = '0;
    s_next = s_reg;
    s_next.wave_valid = 1'b0;
    s_next.rdata = 32'h0000_0000;

    // Register reads; unmapped addresses read zero
    if (bus.rd) begin
      case (bus.addr)
        `REA_ADDR_WAVE_SEL: s_next.rdata = {24'h000000, s_reg.wave_sel};
        `REA_ADDR_NL_CFG: s_next.rdata = {24'h000000, s_reg.nl_cfg};
        `REA_ADDR_ACC_CFG: s_next.rdata = {24'h000000, s_reg.acc_cfg};
        `REA_ADDR_EN_LOW: s_next.rdata = {24'h000000, s_reg.en_low};
        `REA_ADDR_EN_HIGH: s_next.rdata = {24'h000000, s_reg.en_high};
        `REA_ADDR_STATUS: s_next.rdata = {24'h000000, s_reg.status};
        `REA_ADDR_OFFSET: s_next.rdata = {16'h0000, s_reg.offset};
        `REA_ADDR_GAIN: s_next.rdata = {20'h00000, s_reg.gain};
        `REA_ADDR_DIVIDER: s_next.rdata = {24'h000000, s_reg.divider};
        `REA_ADDR_ENERGY: s_next.rdata = {8'h00, s_reg.acc[`REA_ENERGY_HI:`REA_ENERGY_LO]}; // R10
        `REA_ADDR_ENERGY_RC: s_next.rdata = {8'h00, s_reg.acc[`REA_ENERGY_HI:`REA_ENERGY_LO]}; // R17
        `REA_ADDR_WAVE_DATA: s_next.rdata = {8'h00, s_reg.wave_data};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        `REA_ADDR_WAVE_SEL: s_next.wave_sel = bus.wdata[7:0];
        `REA_ADDR_NL_CFG: s_next.nl_cfg = bus.wdata[7:0];
        `REA_ADDR_ACC_CFG: s_next.acc_cfg = bus.wdata[7:0];
        `REA_ADDR_EN_LOW: s_next.en_low = bus.wdata[7:0];
        `REA_ADDR_EN_HIGH: s_next.en_high = bus.wdata[7:0];
        `REA_ADDR_OFFSET: s_next.offset = bus.wdata[15:0];
        `REA_ADDR_GAIN: s_next.gain = bus.wdata[11:0];
        `REA_ADDR_DIVIDER: s_next.divider = bus.wdata[7:0];
        default: ;
      endcase
    end

    // Five-clock accumulation period
    step = (s_reg.phase == PHASE_LAST); // R11
    s_next.phase = step ? 3'h0 : 3'(s_reg.phase + 3'h1); // R11

    acc_n = s_reg.acc;
    if (step) begin
      if (!no_load) begin
        acc_n = acc_sum; // R7 R11
      end else begin
        ev[`REA_ST_NOLOAD_BIT] = 1'b1; // R7
      end
      // Sign change on the selected transition direction
      if (s_reg.prev_valid) begin
        if (!s_reg.acc_cfg[`REA_ACC_POLARITY_BIT]) begin
          ev[`REA_ST_SIGN_BIT] = !s_reg.prev_neg && work_neg; // R4
        end else begin
          ev[`REA_ST_SIGN_BIT] = s_reg.prev_neg && !work_neg; // R5
        end
      end
      s_next.prev_neg = work_neg;
      s_next.prev_valid = 1'b1;
    end

    // Half-full and wrap events on the readable value
    e_old = s_reg.acc[`REA_ENERGY_HI:`REA_ENERGY_LO];
    e_new = acc_n[`REA_ENERGY_HI:`REA_ENERGY_LO];
    if ((e_new[`REA_HALF_BIT] != e_new[23]) && (e_old[`REA_HALF_BIT] == e_old[23])) begin
      ev[`REA_ST_HALF_BIT] = 1'b1; // R20 R22
    end
    if ((e_old[23:22] == 2'h1 && e_new[23:22] == 2'h2) ||
        (e_old[23:22] == 2'h2 && e_new[23:22] == 2'h1)) begin
      ev[`REA_ST_WRAP_BIT] = 1'b1; // R19 R20 R22
    end

    // Read-clear empties the upper part after the read
    if (bus.rd && bus.addr == `REA_ADDR_ENERGY_RC) begin
      acc_n[`REA_ENERGY_HI:`REA_ENERGY_LO] = 24'h000000; // R17
    end
    s_next.acc = acc_n;

    // Write one to clear; a same-cycle event wins
    if (bus.wr && bus.addr == `REA_ADDR_STATUS) begin
      s_next.status = s_reg.status & ~bus.wdata[7:0]; // R23
    end
    s_next.status = s_next.status | ev; // R23

    // One request from all enabled flags, held while any stays set
    s_next.irq = |(s_next.status & s_reg.en_low); // R6 R8 R23

    // Waveform sampling of reactive power at the selected rate
    rate = s_reg.wave_sel[`REA_WAVE_RATE_HI:`REA_WAVE_RATE_LO];
    wlim = 16'(WAVE_CYCLES << rate); // R18
    if (s_reg.en_high[`REA_ENH_WAVEFORM_SAMPLING_ENABLE_BIT] &&
        s_reg.wave_sel[`REA_WAVE_SRC_HI:`REA_WAVE_SRC_LO] == `REA_WAVE_SRC_REACTIVE) begin
      if (s_reg.wave_cnt >= 16'(wlim - 16'h0001)) begin
        s_next.wave_cnt = 16'h0000;
        s_next.wave_valid = 1'b1; // R18
        s_next.wave_data = gained[23:0]; // R18
      end else begin
        s_next.wave_cnt = 16'(s_reg.wave_cnt + 16'h0001);
      end
    end else begin
      s_next.wave_cnt = 16'h0000;
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '{wave_sel: `REA_RST_BYTE, nl_cfg: `REA_RST_BYTE, acc_cfg: `REA_RST_BYTE,
                 en_low: `REA_RST_BYTE, en_high: `REA_RST_BYTE, status: `REA_RST_BYTE,
                 offset: `REA_RST_OFFSET, gain: `REA_RST_GAIN, divider: `REA_RST_BYTE,
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign rdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign wave_data = s_reg.wave_data;
  assign wave_valid = s_reg.wave_valid;

endmodule

// ### rea_accum_sva.sv
// Purpose: Port-level checks of the reactive energy accumulator.
// Assumes: One clock domain; reset asynchronous, active high.
// Notes:   Attached to every accumulator instance by the bind at the foot.
`timescale 1ns/1ps
`include "rea_map.svh"
module rea_accum_sva
  import rea_pkg::*;
#(
  parameter int WAVE_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire rea_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic signed [23:0] reactive_power,
  input wire logic active_power_neg,
  input wire logic irq,
  input wire logic [23:0] wave_data,
  input wire logic wave_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Clocks since the last waveform pulse, saturating
  logic [15:0] gap_reg;
  // Gap counter restarts on each pulse
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_reg <= 16'hFFFF;
    end else if (wave_valid) begin
      gap_reg <= 16'h0001;
    end else if (gap_reg != 16'hFFFF) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end
  chk_rdata_quiet: assert property (!bus.rd |=> rdata == 32'h0)
    else $error("read data present without a read");
  chk_energy_width: assert property (bus.rd && bus.addr == `REA_ADDR_ENERGY
    |=> rdata[31:24] == 8'h0) else $error("energy read wider than 24 bits");
  chk_byte_width: assert property (bus.rd && (bus.addr == `REA_ADDR_DIVIDER
    || bus.addr == `REA_ADDR_NL_CFG) |=> rdata[31:8] == 24'h0) else $error("byte read too wide");
  chk_unmapped_zero: assert property (bus.rd && !(bus.addr inside {[8'h40:8'h45],
    8'h0D, 8'h0E, 8'h0F, 8'hD9, 8'hDB, 8'hDC}) |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_wave_gap: assert property (wave_valid |-> gap_reg >= WAVE_CYCLES)
    else $error("waveform pulses too close");
  chk_wave_hold: assert property ($changed(wave_data) |-> wave_valid)
    else $error("waveform data changed without a pulse");
  chk_irq_held: assert property ($fell(irq) |-> ($past(bus.wr) &&
    $past(bus.addr) == `REA_ADDR_STATUS) || ($past(bus.wr, 2) &&
    $past(bus.addr, 2) == `REA_ADDR_EN_LOW))
    else $error("interrupt dropped without software action");
  chk_irq_mask: assert property (bus.wr && bus.addr == `REA_ADDR_EN_LOW
    && bus.wdata[7:0] == 8'h0 |=> ##1 !irq) else $error("masked interrupt still high");
endmodule
bind rea_accum rea_accum_sva #(.WAVE_CYCLES(WAVE_CYCLES)) u_sva (.clk(clk), .reset(reset),
  .bus(bus), .rdata(rdata), .reactive_power(reactive_power),
  .active_power_neg(active_power_neg), .irq(irq), .wave_data(wave_data),
  .wave_valid(wave_valid));

// ### rea_cpu_model.sv
// Purpose: Core-side register master for the accumulator.
// Assumes: One-cycle strobes, read data in the following cycle.
// Notes:   Idle address and data show inverted values, never stale ones.
`timescale 1ns/1ps
module rea_cpu_model
  import rea_pkg::*;
(
  input wire logic clk,
  output rea_bus_t bus,
  input wire logic [31:0] rdata
);
  initial bus = '0;
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
  endtask
  // One-cycle read strobe; data taken in the answer cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: 32'hFFFFFFFF, wr: 1'b0, rd: 1'b0};
    #1;
    v = rdata;
  endtask
endmodule

// ### testbench.sv
// Purpose: Self-checking bench of the reactive energy accumulator.
// Assumes: Waveform period shortened to four clocks.
// Notes:   Mode cases run from a table; the rest are hand-written.
`timescale 1ns/1ps
`include "rea_map.svh"
module testbench;
  import rea_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] div;
    logic [23:0] q;
    logic apn;
    logic [23:0] step;
  } rea_row_t;
  // Mode, divider, power, active sign, energy change per step
  rea_row_t rows [8] = '{'{8'h00, 8'h00, 24'h400000, 1'b0, 24'h000020},
    '{8'h00, 8'h04, 24'h400000, 1'b0, 24'h000008}, '{8'h00, 8'h01, 24'hC00000, 1'b0, 24'hFFFFE0},
    '{8'h04, 8'h00, 24'h400000, 1'b1, 24'hFFFFE0}, '{8'h04, 8'h00, 24'hC00000, 1'b1, 24'h000020},
    '{8'h04, 8'h00, 24'h400000, 1'b0, 24'h000020}, '{8'h08, 8'h00, 24'hC00000, 1'b0, 24'h000020},
    '{8'h0C, 8'h00, 24'hC00000, 1'b1, 24'h000020}};
  logic [7:0] raddr [12] = '{8'h0D, 8'h0E, 8'h0F, 8'hD9, 8'hDB, 8'hDC, 8'h40, 8'h41, 8'h42,
    8'h43, 8'h45, 8'h77};
  logic clk;
  logic reset;
  rea_bus_t bus;
  logic [31:0] rdata;
  logic signed [23:0] power;
  logic apn;
  logic irq;
  logic [23:0] wave_data;
  logic wave_valid;
  logic [31:0] d;
  logic [31:0] e;
  int mismatches;
  int comparisons;
  rea_cpu_model u_cpu (.clk(clk), .bus(bus), .rdata(rdata));
  rea_accum #(.WAVE_CYCLES(4)) u_dut (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .reactive_power(power), .active_power_neg(apn), .irq(irq), .wave_data(wave_data),
    .wave_valid(wave_valid));
  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Energy change over exactly four accumulation periods
  task automatic span(input logic [23:0] step);
    logic [31:0] e0;
    logic [23:0] dlt;
    u_cpu.rd(`REA_ADDR_ENERGY, e0);
    repeat (18) @(posedge clk);
    u_cpu.rd(`REA_ADDR_ENERGY, d);
    dlt = d[23:0] - e0[23:0];
    check("energy delta", {8'h0, dlt}, {8'h0, step << 2});
  endtask
  // Clear flags, move power, look at the sign flag
  task automatic sgn(input logic [23:0] q, input logic exp);
    u_cpu.wr(`REA_ADDR_STATUS, 32'hFF);
    power <= q;
    repeat (12) @(posedge clk);
    u_cpu.rd(`REA_ADDR_STATUS, d);
    check("sign flag", {31'h0, d[`REA_ST_SIGN_BIT]}, {31'h0, exp});
  endtask
  // Threshold mode, power and offset against the no-load flag
  task automatic nl(input logic [1:0] m, input logic [23:0] q, input logic [15:0] off,
      input logic exp);
    u_cpu.wr(`REA_ADDR_NL_CFG, {28'h0, m, 2'h0});
    u_cpu.wr(`REA_ADDR_OFFSET, {16'h0, off});
    power <= q;
    u_cpu.wr(`REA_ADDR_STATUS, 32'hFF);
    repeat (8) @(posedge clk);
    u_cpu.rd(`REA_ADDR_STATUS, d);
    check("no-load flag", {31'h0, d[`REA_ST_NOLOAD_BIT]}, {31'h0, exp});
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    power = 24'h0;
    apn = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      u_cpu.wr(`REA_ADDR_ACC_CFG, {24'h0, rows[i].cfg});
      u_cpu.wr(`REA_ADDR_DIVIDER, {24'h0, rows[i].div});
      power <= rows[i].q;
      apn <= rows[i].apn;
      span(rows[i].step);
    end
    u_cpu.wr(`REA_ADDR_ACC_CFG, 32'h0);
    u_cpu.wr(`REA_ADDR_EN_LOW, 32'h1);
    sgn(24'h400000, 1'b0);
    sgn(24'hC00000, 1'b1);
    repeat (4) @(negedge clk);
    check("irq held", {31'h0, irq}, 32'h1);
    u_cpu.wr(`REA_ADDR_STATUS, 32'h1);
    repeat (3) @(negedge clk);
    check("irq after clear", {31'h0, irq}, 32'h0);
    u_cpu.wr(`REA_ADDR_ACC_CFG, 32'h80);
    sgn(24'h400000, 1'b1);
    sgn(24'hC00000, 1'b0);
    u_cpu.wr(`REA_ADDR_ACC_CFG, 32'h0);
    u_cpu.wr(`REA_ADDR_EN_LOW, 32'h0);
    u_cpu.wr(`REA_ADDR_EN_LOW, 32'h2);
    nl(2'h2, 24'h0002BC, 16'h0000, 1'b0);
    nl(2'h3, 24'h00012C, 16'h0000, 1'b1);
    nl(2'h0, 24'h00012C, 16'h0000, 1'b0);
    nl(2'h1, 24'h0004EB, 16'h0000, 1'b0);
    nl(2'h1, 24'h0004EA, 16'h0100, 1'b0);
    nl(2'h1, 24'h0004EB, 16'hFF00, 1'b1);
    check("irq no-load", {31'h0, irq}, 32'h1);
    power <= 24'h0;
    u_cpu.rd(`REA_ADDR_ENERGY, e);
    u_cpu.rd(`REA_ADDR_ENERGY_RC, d);
    check("read-clear value", d, e);
    u_cpu.rd(`REA_ADDR_ENERGY, d);
    check("energy after clear", d, 32'h0);
    u_cpu.wr(`REA_ADDR_GAIN, 32'h400);
    u_cpu.wr(`REA_ADDR_EN_HIGH, 32'h1);
    u_cpu.wr(`REA_ADDR_WAVE_SEL, 32'h3);
    power <= 24'h001000;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 40 && wave_valid !== 1'b1; i++) @(negedge clk);
    check("wave sample", {8'h0, wave_data}, 32'h1400);
    @(posedge clk);
    power <= 24'h0;
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    check("irq after reset", {31'h0, irq}, 32'h0);
    foreach (raddr[i]) begin
      u_cpu.rd(raddr[i], d);
      check("reset value", d, 32'h0);
    end
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
